// ===== src/sic_pkg.sv
/*
 package of the byte-oriented i2c master channel: register map, field layout,
 reset values, engine states and timing counts.
 assumes a 125 MHz pclk and an apb master with 32-bit data.
*/
// Function
// - raise byte_done interrupt when each sent byte and its ack clock finish
// - record ack outcome in ack_error_flag after every sent byte
// - start: sda low first, scl low only after start hold time
// - after start enable output, start channel, shift_data_reg write sends address
// - end write: stop channel, output off, sda low, scl high, later release sda
// - restart: stop channel, output off, raise scl with sda high, then sda low
// - after read address, stop channel, set receive-only config, restart channel
// - each received byte starts on a dummy all-ones shift_data_reg write
// - with output enabled, receive drives ack on ninth clock then interrupt
// - last byte: output disabled, sda high on ninth clock gives nack, interrupt
// - after last nack stop channel, restore transmit config, then stop sequence
// - words are eight bits, msb first, no parity, one ack slot
// - scl clock derived by division, sample setting near 381 kHz fast mode
package sic_pkg;
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 8;
	localparam int unsigned HOLD_STD_NS     = 4000;
	localparam int unsigned HOLD_FAST_NS    = 600;
	localparam int unsigned SCL_FAST_HZ     = 381_000;
	localparam int unsigned HOLD_STD_CYC    = (HOLD_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_FAST_CYC   = (HOLD_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SCL_HALF_CYC    = CLK_HZ / (2 * SCL_FAST_HZ);
	localparam int unsigned TMR_W           = 10;
	localparam int unsigned BIT_W           = 4;
	localparam logic [3:0]  LAST_BIT        = 4'h8;
	localparam logic [7:0]  ADDR_CFG        = 8'h00;
	localparam logic [7:0]  ADDR_START      = 8'h04;
	localparam logic [7:0]  ADDR_STOP       = 8'h08;
	localparam logic [7:0]  ADDR_SOE        = 8'h0c;
	localparam logic [7:0]  ADDR_SO         = 8'h10;
	localparam logic [7:0]  ADDR_SIO        = 8'h14;
	localparam logic [7:0]  ADDR_STAT       = 8'h18;
	localparam logic [7:0]  ADDR_ISTAT      = 8'h1c;
	localparam logic [7:0]  ADDR_IMASK      = 8'h20;
	localparam int unsigned CFG_TX          = 0;
	localparam int unsigned CFG_RX          = 1;
	localparam int unsigned CFG_FAST        = 2;
	localparam int unsigned SO_SDA          = 0;
	localparam int unsigned SO_SCL          = 1;
	localparam int unsigned ST_ACKERR       = 0;
	localparam int unsigned ST_BUSY         = 1;
	localparam int unsigned ST_EN           = 2;
	localparam logic [2:0]  CFG_RST         = 3'h5;
	localparam logic [1:0]  SO_RST          = 2'h3;
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b001,
		ENG_LOW  = 3'b010,
		ENG_HIGH = 3'b100
	} sic_eng_t;
endpackage : sic_pkg

// ===== src/sic_sync.sv
/*
 two-flop synchroniser for the scl and sda pin inputs.
 assumes the inputs are asynchronous to pclk.
*/
`timescale 1ns/1ns
module sic_sync (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] d,
	output logic      [1:0] q
);
	logic [1:0] meta_r;

	// first stage feeds the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 2'h3;
			q      <= 2'h3;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : sic_sync

// ===== src/sic_shift.sv
/*
 shift engine: clocks out one byte msb first plus one ack slot, sampling sda
 at the end of each scl high phase.
 assumes sda_in is already synchronised to pclk.
*/
`timescale 1ns/1ns
module sic_shift (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [7:0] tx_byte,
	input  wire logic       ack_bit,
	input  wire logic       sda_in,
	output logic            scl_q,
	output logic            sda_q,
	output logic            busy,
	output logic            done,
	output logic      [7:0] rx_byte,
	output logic            ack_sample
);
	sic_pkg::sic_eng_t                  st_r;
	logic [8:0]                         sh_r;
	logic [sic_pkg::BIT_W-1:0]          bit_r;
	logic [sic_pkg::TMR_W-1:0]          div_r;
	logic                               half_end;

	assign half_end = (div_r == sic_pkg::TMR_W'(sic_pkg::SCL_HALF_CYC - 1));
	assign busy     = (st_r != sic_pkg::ENG_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= sic_pkg::ENG_IDLE;
			sh_r       <= 9'h1ff;
			bit_r      <= '0;
			div_r      <= '0;
			scl_q      <= 1'b0;
			sda_q      <= 1'b1;
			done       <= 1'b0;
			rx_byte    <= 8'h00;
			ack_sample <= 1'b1;
		end else begin
			done <= 1'b0;
			case (st_r)
				sic_pkg::ENG_IDLE: begin
					if (go) begin
						sh_r  <= {tx_byte, ack_bit};
						sda_q <= tx_byte[7];
						bit_r <= '0;
						div_r <= '0;
						st_r  <= sic_pkg::ENG_LOW;
					end
				end
				sic_pkg::ENG_LOW: begin
					div_r <= div_r + 1'b1;
					if (half_end) begin
						div_r <= '0;
						scl_q <= 1'b1;
						st_r  <= sic_pkg::ENG_HIGH;
					end
				end
				sic_pkg::ENG_HIGH: begin
					div_r <= div_r + 1'b1;
					if (half_end) begin
						div_r <= '0;
						scl_q <= 1'b0;
						if (bit_r == sic_pkg::LAST_BIT) begin
							ack_sample <= sda_in;
							sda_q      <= 1'b1;
							done       <= 1'b1;
							st_r       <= sic_pkg::ENG_IDLE;
						end else begin
							rx_byte <= {rx_byte[6:0], sda_in};
							sh_r    <= {sh_r[7:0], 1'b1};
							sda_q   <= sh_r[7];
							bit_r   <= bit_r + 1'b1;
							st_r    <= sic_pkg::ENG_LOW;
						end
					end
				end
				default: st_r <= sic_pkg::ENG_IDLE;
			endcase
		end
	end
endmodule : sic_shift

// ===== src/sic_top.sv
/*
 byte-oriented i2c master channel with an apb register file, direct scl/sda
 level control, a shift channel and a masked byte-done interrupt.
 assumes open-drain pins with external pull-ups and a single i2c master.
*/
`timescale 1ns/1ns
module sic_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	logic [2:0]                 cfg_r;
	logic                       en_r;
	logic                       soe_r;
	logic [1:0]                 so_r;
	logic                       sda_lvl_r;
	logic                       scl_lvl_r;
	logic [sic_pkg::TMR_W-1:0]  tmr_r;
	logic                       ackerr_r;
	logic                       istat_r;
	logic                       imask_r;
	logic                       go_r;
	logic [7:0]                 txb_r;
	logic [1:0]                 pin_s;
	logic                       eng_scl;
	logic                       eng_sda;
	logic                       eng_busy;
	logic                       eng_done;
	logic [7:0]                 eng_rx;
	logic                       eng_ack;
	logic                       acc;
	logic                       wr;
	logic [sic_pkg::TMR_W-1:0]  hold_cyc;
	logic                       hold_ok;
	logic                       scl_val;
	logic                       sda_val;
	logic                       own_r;

	function automatic logic sic_mapped(input logic [7:0] a);
		sic_mapped = (a == sic_pkg::ADDR_CFG)   || (a == sic_pkg::ADDR_START) ||
		             (a == sic_pkg::ADDR_STOP)  || (a == sic_pkg::ADDR_SOE)   ||
		             (a == sic_pkg::ADDR_SO)    || (a == sic_pkg::ADDR_SIO)   ||
		             (a == sic_pkg::ADDR_STAT)  || (a == sic_pkg::ADDR_ISTAT) ||
		             (a == sic_pkg::ADDR_IMASK);
	endfunction : sic_mapped

	function automatic logic sic_wr_to(input logic w, input logic [7:0] a,
		input logic [7:0] r);
		sic_wr_to = w && (a == r) && sic_mapped(a);
	endfunction : sic_wr_to

	// every access answers one cycle into its access phase
	assign acc = psel && penable && !pready;
	assign wr  = acc && pwrite;

	sic_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({scl_i, sda_i}),
		.q       (pin_s)
	);

	sic_shift u_shift (
		.pclk       (pclk),
		.presetn    (presetn),
		.go         (go_r),
		.tx_byte    (txb_r),
		.ack_bit    (cfg_r[sic_pkg::CFG_TX]), // transmit releases the ack slot
		.sda_in     (pin_s[0]),
		.scl_q      (eng_scl),
		.sda_q      (eng_sda),
		.busy       (eng_busy),
		.done       (eng_done),
		.rx_byte    (eng_rx),
		.ack_sample (eng_ack)
	);

	// apb handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc;
			pslverr <= acc && !sic_mapped(paddr);
			if (acc && !pwrite) begin
				case (paddr)
					sic_pkg::ADDR_CFG:   prdata <= {29'h0, cfg_r};
					sic_pkg::ADDR_SOE:   prdata <= {31'h0, soe_r};
					sic_pkg::ADDR_SO:    prdata <= {30'h0, so_r};
					sic_pkg::ADDR_SIO:   prdata <= {24'h0, eng_rx};
					sic_pkg::ADDR_STAT:  prdata <= {29'h0, en_r, eng_busy || go_r, ackerr_r};
					sic_pkg::ADDR_ISTAT: prdata <= {31'h0, istat_r};
					sic_pkg::ADDR_IMASK: prdata <= {31'h0, imask_r};
					default:             prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// config only changes while the channel is stopped, so a direction switch
	// mid-byte cannot corrupt the ack slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= sic_pkg::CFG_RST;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_CFG) && !en_r) begin
			cfg_r <= pwdata[2:0];
		end
	end

	// channel run state; stop wins over start in the same write stream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= 1'b0;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_STOP) && pwdata[0]) begin
			en_r <= 1'b0;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_START) && pwdata[0]) begin
			en_r <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soe_r <= 1'b0;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_SOE)) begin
			soe_r <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_r <= sic_pkg::SO_RST;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_SO)) begin
			so_r <= pwdata[1:0];
		end
	end

	// a shift_data_reg write while the channel runs and is idle kicks a byte;
	// writes while busy or stopped are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_r  <= 1'b0;
			txb_r <= 8'hff;
		end else begin
			go_r <= 1'b0;
			if (sic_wr_to(wr, paddr, sic_pkg::ADDR_SIO) && en_r && !eng_busy && !go_r) begin
				go_r  <= 1'b1;
				txb_r <= pwdata[7:0];
			end
		end
	end

	// ack outcome of each transmitted byte; receive bytes leave it cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ackerr_r <= 1'b0;
		end else if (eng_done) begin
			ackerr_r <= cfg_r[sic_pkg::CFG_TX] && eng_ack;
		end
	end

	// bus-timing guard on the directly driven levels
	assign hold_cyc = cfg_r[sic_pkg::CFG_FAST] ? sic_pkg::TMR_W'(sic_pkg::HOLD_FAST_CYC)
	                                           : sic_pkg::TMR_W'(sic_pkg::HOLD_STD_CYC);
	assign hold_ok  = (tmr_r >= hold_cyc);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_lvl_r <= 1'b1;
			scl_lvl_r <= 1'b1;
			tmr_r     <= '0;
		end else begin
			if (!hold_ok) begin
				tmr_r <= tmr_r + 1'b1;
			end
			// sda falls freely: start and restart edges come first
			if (so_r[sic_pkg::SO_SDA] != sda_lvl_r) begin
				if (!so_r[sic_pkg::SO_SDA] || !scl_lvl_r || hold_ok) begin
					sda_lvl_r <= so_r[sic_pkg::SO_SDA];
					tmr_r     <= '0;
				end
			end else if (so_r[sic_pkg::SO_SCL] != scl_lvl_r) begin
				if (so_r[sic_pkg::SO_SCL] || sda_lvl_r || hold_ok) begin
					scl_lvl_r <= so_r[sic_pkg::SO_SCL];
					tmr_r     <= '0;
				end
			end
		end
	end

	// pin mux: the running channel owns both lines; with output disabled the
	// data line stays released, which is the nack on the last byte
	// the engine takes the pins only once scl_oe shows scl driven low, so an early
	// start cannot cut the start hold short or move sda while scl is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_r <= 1'b0;
		end else begin
			own_r <= en_r && (own_r || scl_oe);
		end
	end

	assign scl_val = own_r ? eng_scl : scl_lvl_r;
	assign sda_val = own_r ? (soe_r ? eng_sda : 1'b1) : sda_lvl_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_o  <= 1'b0;
			scl_oe <= 1'b0;
			sda_o  <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_o  <= 1'b0;
			scl_oe <= !scl_val;
			sda_o  <= 1'b0;
			sda_oe <= !sda_val;
		end
	end

	// sticky byte-done status; a new event beats a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= 1'b0;
		end else if (eng_done) begin
			istat_r <= 1'b1;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_ISTAT) && pwdata[0]) begin
			istat_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask_r <= 1'b0;
		end else if (sic_wr_to(wr, paddr, sic_pkg::ADDR_IMASK)) begin
			imask_r <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= istat_r && imask_r;
		end
	end
endmodule : sic_top

// ===== sim/sic_checker.sv
/* port checker for sic_top, bound to every instance.
 assumes the fast-mode start hold of 75 pclk cycles and a one-wait apb slave. */
`timescale 1ns/1ns
module sic_checker (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       irq,
	input wire logic       scl_oe,
	input wire logic       sda_oe
);
	// saturating count of cycles with sda low under a released scl
	logic [9:0] hold_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hold_r <= 10'h000;
		else hold_r <= (sda_oe && !scl_oe) ? hold_r + {9'h000, hold_r != 10'h3ff} : 10'h000;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_start_hold;
		$rose(scl_oe) && $past(sda_oe) |-> hold_r >= 10'h04b;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start hold short");
	property p_stop_setup;
		$fell(sda_oe) && !scl_oe |-> hold_r >= 10'h04b;
	endproperty
	a_stop_setup: assert property (p_stop_setup) else $error("stop setup short");
	property p_irq_idle;
		$rose(irq) |-> scl_oe;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq before byte end");
	property p_rdy_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
	property p_rdy_cause;
		pready |-> $past(penable) && psel;
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
	property p_err_map;
		pready |-> pslverr == !((paddr[1:0] == 2'h0) && (paddr <= 8'h20));
	endproperty
	a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
	property p_err_only;
		pslverr |-> pready;
	endproperty
	a_err_only: assert property (p_err_only) else $error("pslverr outside pready");
endmodule : sic_checker
bind sic_top sic_checker chk_i (.pclk, .presetn, .psel, .penable, .paddr, .pready,
	.pslverr, .irq, .scl_oe, .sda_oe);

// ===== sim/sic_slave.sv
/* behavioural i2c slave: acks its own address, keeps the last written byte
 and answers reads with 0xc3 then 0x3c.
 assumes the bench resolves both open-drain lines with pull-ups. */
`timescale 1ns/1ns
module sic_slave #(parameter logic [6:0] DEV_ADDR = 7'h50) (
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_pull,
	output logic      [7:0] got,
	output logic            ack_seen
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00, tx = 8'hc3;
	logic       act = 1'b0, rd = 1'b0, first = 1'b0;
	initial begin
		sda_pull = 1'b0;
		got = 8'h00;
		ack_seen = 1'b0;
	end
	// settle first: a data change at the falling scl edge is no start
	always @(negedge sda) begin
		#1;
		if (scl === 1'b1) begin
			cnt = 4'h0;
			act = 1'b1;
			first = 1'b1;
		end
	end
	always @(posedge sda) begin
		#1;
		if (scl === 1'b1) act = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda};
		else ack_seen = ~sda;
		cnt = cnt + 4'h1;
	end
	always @(negedge scl) if (act) begin
		if (cnt == 4'h8) begin
			if (first) rd = sh[0];
			if (first) act = (sh[7:1] == DEV_ADDR);
			if (!first && !rd) got = sh;
			sda_pull = act && (first || !rd);
		end else if (cnt == 4'h9) begin
			if (rd && !first) tx = ~tx;
			sda_pull = rd && (first || ack_seen) && !tx[7];
			cnt = 4'h0;
			first = 1'b0;
		end else if (rd && !first) begin
			sda_pull = !tx[3'h7 - cnt[2:0]];
		end
	end
endmodule : sic_slave

// ===== sim/tb.sv
/* self-checking bench for sic_top: apb tasks and an i2c slave at 0x50.
 assumes pull-ups on both lines and a 125 MHz pclk. */
`timescale 1ns/1ns
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic        scl_o, scl_oe, sda_o, sda_oe, pull, ack_seen;
	logic [7:0]  paddr, got;
	logic [31:0] pwdata, prdata, q;
	int          n_fail = 0, checks_done = 0, cyc = 0;
	wire         scl = scl_oe ? scl_o : 1'b1;
	wire         sda = (sda_oe ? sda_o : 1'b1) & ~pull;
	sic_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
	sic_slave slv (.scl, .sda, .sda_pull(pull), .got, .ack_seen);
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	// request held until the edge that samples pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rc
	task automatic start_seq();
		wr(sic_pkg::ADDR_SO, 32'h2);
		wr(sic_pkg::ADDR_SO, 32'h0);
		wr(sic_pkg::ADDR_SOE, 32'h1);
		wr(sic_pkg::ADDR_START, 32'h1);
	endtask : start_seq
	task automatic stop_seq();
		wr(sic_pkg::ADDR_STOP, 32'h1);
		wr(sic_pkg::ADDR_SOE, 32'h0);
		wr(sic_pkg::ADDR_SO, 32'h0);
		wr(sic_pkg::ADDR_SO, 32'h2);
		wr(sic_pkg::ADDR_SO, 32'h3);
		while (sda !== 1'b1) @(posedge pclk);
	endtask : stop_seq
	// m is the irq level expected while the byte-done bit is pending
	task automatic byte_xfer(input logic [7:0] b, input logic m);
		int i;
		wr(sic_pkg::ADDR_SIO, {24'h0, b});
		q = 32'h0;
		for (i = 0; i < 2000 && q[0] !== 1'b1; i++) xfer(1'b0, sic_pkg::ADDR_ISTAT, 32'h0);
		chk("irq", {31'h0, m}, {31'h0, irq});
		wr(sic_pkg::ADDR_IMASK, 32'h1);
		chk("irq_unmasked", 32'h1, {31'h0, irq});
		wr(sic_pkg::ADDR_ISTAT, 32'h1);
		chk("irq_cleared", 32'h0, {31'h0, irq});
	endtask : byte_xfer
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("cfg", sic_pkg::ADDR_CFG, 32'h5);
		rc("levels", sic_pkg::ADDR_SO, 32'h3);
		rc("imask", sic_pkg::ADDR_IMASK, 32'h0);
		xfer(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		xfer(1'b0, 8'h02, 32'h0);
		chk("slverr_odd", 32'h1, {31'h0, err});
		$display("register test done");
		start_seq();
		byte_xfer(8'ha0, 1'b0);
		rc("ack_addr", sic_pkg::ADDR_STAT, 32'h4);
		wr(sic_pkg::ADDR_CFG, 32'h6);
		rc("cfg_locked", sic_pkg::ADDR_CFG, 32'h5);
		byte_xfer(8'h5a, 1'b1);
		chk("slave_byte", 32'h5a, {24'h0, got});
		rc("ack_data", sic_pkg::ADDR_STAT, 32'h4);
		wr(sic_pkg::ADDR_STOP, 32'h1);
		wr(sic_pkg::ADDR_SOE, 32'h0);
		wr(sic_pkg::ADDR_SO, 32'h1);
		wr(sic_pkg::ADDR_SO, 32'h3);
		start_seq();
		byte_xfer(8'ha1, 1'b1);
		wr(sic_pkg::ADDR_STOP, 32'h1);
		wr(sic_pkg::ADDR_CFG, 32'h6);
		rc("cfg_rx", sic_pkg::ADDR_CFG, 32'h6);
		wr(sic_pkg::ADDR_START, 32'h1);
		byte_xfer(8'hff, 1'b1);
		rc("rx_first", sic_pkg::ADDR_SIO, 32'hc3);
		chk("master_ack", 32'h1, {31'h0, ack_seen});
		wr(sic_pkg::ADDR_SOE, 32'h0);
		byte_xfer(8'hff, 1'b1);
		rc("rx_last", sic_pkg::ADDR_SIO, 32'h3c);
		chk("master_nack", 32'h0, {31'h0, ack_seen});
		wr(sic_pkg::ADDR_STOP, 32'h1);
		wr(sic_pkg::ADDR_CFG, 32'h5);
		rc("cfg_tx", sic_pkg::ADDR_CFG, 32'h5);
		stop_seq();
		wr(sic_pkg::ADDR_SIO, 32'h0);
		rc("idle", sic_pkg::ADDR_STAT, 32'h0);
		$display("write and read test done");
		wr(sic_pkg::ADDR_CFG, 32'h1);
		wr(sic_pkg::ADDR_SO, 32'h2);
		wr(sic_pkg::ADDR_SO, 32'h0);
		repeat (480) @(posedge pclk);
		chk("std_hold_high", 32'h1, {31'h0, scl});
		repeat (40) @(posedge pclk);
		chk("std_hold_low", 32'h0, {31'h0, scl});
		wr(sic_pkg::ADDR_SOE, 32'h1);
		wr(sic_pkg::ADDR_START, 32'h1);
		byte_xfer(8'hb0, 1'b1);
		rc("nack_addr", sic_pkg::ADDR_STAT, 32'h5);
		stop_seq();
		$display("nack test done");
		close_out();
	end
endmodule : tb
